//--- ebrt_timer.sv
// Purpose: eight-bit up timer with interval and auto-reload modes
// Assumes: AXI4-Lite register access, one clock, async active-high reset
// Notes: counter and reload register share one index
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module ebrt_timer
    import ebrt_pkg::*;
#(
    parameter logic [13:0] SLOW_DIV = DIV_8192
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic event_input_pin,
    input wire logic event_edge_select,
    input wire logic low_power_halt,
    output logic irq
);
    ebrt_tick_if tk ();

    logic reload_mode_q;
    logic [2:0] clock_source_q;
    logic [7:0] count_q;
    logic [7:0] reload_q;
    logic ovf_flag_q;
    logic ovf_en_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic aw_have_q;
    logic w_have_q;
    ebrt_wr_t wr_q;
    ebrt_rd_t rd_q;
    logic do_write;
    logic wr_mode;
    logic wr_load;
    logic wr_stat;
    logic wr_mask;
    logic wr_hit;
    logic adv;
    logic ovf;
    logic [7:0] mode_rd;
    logic [31:0] rd_val;
    logic rd_hit;

    function automatic logic is_idx(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
        is_idx = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
    endfunction : is_idx

    // ****************************************
    // Tick sources
    // ****************************************
    assign tk.clk_sel = clock_source_q;
    assign tk.halt = low_power_halt;
    assign tk.edge_rise = event_edge_select;

    ebrt_prescaler #(.SLOW_DIV(SLOW_DIV)) u_pre (
        .clk(clk),
        .rst(rst),
        .tk(tk.prescaler)
    );

    ebrt_event_sync u_evt (
        .clk(clk),
        .rst(rst),
        .pin(event_input_pin),
        .tk(tk.evsync)
    );

    // ****************************************
    // Write channel
    // ****************************************
    // Address and data are taken in either order and held until both are in
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_have_q <= 1'b0;
            awaddr_q <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (do_write) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            w_have_q <= 1'b0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_have_q <= 1'b0;
        end
    end

    always_comb begin
        do_write = (wr_q == EBRT_WR_COLLECT) && aw_have_q && w_have_q;
        wr_mode = do_write && wlane_q && is_idx(awaddr_q, MODE_IDX);
        wr_load = do_write && wlane_q && is_idx(awaddr_q, COUNT_IDX);
        wr_stat = do_write && wlane_q && is_idx(awaddr_q, STAT_IDX);
        wr_mask = do_write && wlane_q && is_idx(awaddr_q, MASK_IDX);
        wr_hit = is_idx(awaddr_q, MODE_IDX) || is_idx(awaddr_q, COUNT_IDX)
            || is_idx(awaddr_q, STAT_IDX) || is_idx(awaddr_q, MASK_IDX);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wr_q <= EBRT_WR_COLLECT;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            case (wr_q)
                EBRT_WR_COLLECT: begin
                    s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready);
                    s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready);
                    if (do_write) begin
                        wr_q <= EBRT_WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                    end
                end
                EBRT_WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_q <= EBRT_WR_COLLECT;
                        s_axi_bvalid <= 1'b0;
                        s_axi_awready <= 1'b1;
                        s_axi_wready <= 1'b1;
                    end
                end
                default: begin
                    wr_q <= EBRT_WR_COLLECT;
                end
            endcase
        end
    end

    // ****************************************
    // Mode register
    // ****************************************
    // Only bit 7 and the source field are stored; the rest are constant
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reload_mode_q <= MODE_RST[MODE_BIT];
            clock_source_q <= SRC_RST;
        end else if (wr_mode) begin
            reload_mode_q <= wbyte_q[MODE_BIT];
            clock_source_q <= wbyte_q[SRC_HI:0];
        end
    end

    always_comb begin
        mode_rd = {reload_mode_q, MODE_RSVD, clock_source_q};
    end

    // ****************************************
    // Counter and reload
    // ****************************************
    always_comb begin
        if (clock_source_q == SRC_EVENT) begin
            adv = tk.evt_tick && !low_power_halt;
        end else begin
            // Gate here too: a tick launched just before halt must not count
            adv = tk.pre_tick && !low_power_halt;
        end
        ovf = adv && (count_q == COUNT_TOP);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reload_q <= RELOAD_RST;
        end else if (wr_load) begin
            reload_q <= wbyte_q;
        end
    end

    // Free-running from reset; a load write beats a same-cycle tick
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= COUNT_RST;
        end else if (wr_load) begin
            count_q <= wbyte_q;
        end else if (ovf) begin
            count_q <= reload_mode_q ? reload_q : COUNT_RST;
        end else if (adv) begin
            count_q <= count_q + 8'h01;
        end
    end

    // ****************************************
    // Interrupt status and mask
    // ****************************************
    // Overflow in the clearing cycle still sets the flag
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovf_flag_q <= 1'b0;
        end else if (ovf) begin
            ovf_flag_q <= 1'b1;
        end else if (wr_stat && wbyte_q[OVF_BIT]) begin
            ovf_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ovf_en_q <= 1'b0;
        end else if (wr_mask) begin
            ovf_en_q <= wbyte_q[OVF_BIT];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq <= 1'b0;
        end else begin
            irq <= ovf_flag_q && ovf_en_q;
        end
    end

    // ****************************************
    // Read channel
    // ****************************************
    // Reading the count is side-effect free
    always_comb begin
        rd_hit = 1'b1;
        rd_val = 32'h0000_0000;
        if (is_idx(s_axi_araddr, MODE_IDX)) begin
            rd_val[7:0] = mode_rd;
        end else if (is_idx(s_axi_araddr, COUNT_IDX)) begin
            rd_val[7:0] = count_q;
        end else if (is_idx(s_axi_araddr, STAT_IDX)) begin
            rd_val[OVF_BIT] = ovf_flag_q;
        end else if (is_idx(s_axi_araddr, MASK_IDX)) begin
            rd_val[OVF_BIT] = ovf_en_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_q <= EBRT_RD_IDLE;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            case (rd_q)
                EBRT_RD_IDLE: begin
                    if (s_axi_arvalid && s_axi_arready) begin
                        rd_q <= EBRT_RD_RESP;
                        s_axi_arready <= 1'b0;
                        s_axi_rvalid <= 1'b1;
                        s_axi_rdata <= rd_val;
                        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                    end else begin
                        s_axi_arready <= 1'b1;
                    end
                end
                EBRT_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_q <= EBRT_RD_IDLE;
                        s_axi_rvalid <= 1'b0;
                        s_axi_arready <= 1'b1;
                    end
                end
                default: begin
                    rd_q <= EBRT_RD_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    reset_values_a: assert property (disable iff (1'b0) rst |=> (count_q == COUNT_RST
        && reload_q == RELOAD_RST && mode_rd == MODE_RST))
        else $error("reset values wrong");

    count_step_a: assert property (adv && !wr_load && count_q != COUNT_TOP
        |=> count_q == $past(count_q) + 8'h01)
        else $error("counter did not step by one");

    rsvd_ones_a: assert property (wr_mode |=> mode_rd[6:3] == MODE_RSVD
        && mode_rd[SRC_HI:0] == $past(wbyte_q[SRC_HI:0]))
        else $error("mode write readback wrong");

    mode_write_a: assert property (wr_mode |=> reload_mode_q == $past(wbyte_q[MODE_BIT]))
        else $error("mode bit not taken");

    ovf_flag_a: assert property (adv && count_q == COUNT_TOP |=> ovf_flag_q)
        else $error("overflow did not set flag");

    irq_gate_a: assert property (1'b1 |=> irq == ($past(ovf_flag_q) && $past(ovf_en_q)))
        else $error("interrupt not gated by enable");

    interval_wrap_a: assert property (ovf && !wr_load && !reload_mode_q
        |=> count_q == COUNT_RST ##1 ($past(wr_load) || count_q <= 8'h01))
        else $error("interval wrap wrong");

    load_copy_a: assert property (wr_load |=> count_q == $past(wbyte_q)
        && reload_q == $past(wbyte_q))
        else $error("load write not copied");

    auto_reload_a: assert property (ovf && !wr_load && reload_mode_q
        |=> count_q == $past(reload_q))
        else $error("auto reload wrong");

    halt_hold_a: assert property (low_power_halt && !wr_load |=> $stable(count_q))
        else $error("counter moved while halted");

    read_count_a: assert property (s_axi_arvalid && s_axi_arready
        && is_idx(s_axi_araddr, COUNT_IDX) |=> s_axi_rdata[7:0] == $past(count_q))
        else $error("count read wrong");

    reload_ovf_c: cover property (ovf && reload_mode_q);
    event_count_c: cover property (adv && clock_source_q == SRC_EVENT);
    irq_raise_c: cover property ($rose(irq));
    clear_race_c: cover property (ovf && wr_stat);
endmodule : ebrt_timer
`default_nettype wire

//--- ebrt_pkg.sv
// Purpose: shared constants for the eight-bit reload event timer
// Assumes: AXI4-Lite slave with 32-bit data and word-index addressing
// Notes: printed offsets are word indices; byte address is index times four

// ****************************************
// Timer constants
// ****************************************
package ebrt_pkg;
    localparam int unsigned ADDR_W = 18;
    localparam logic [15:0] MODE_IDX = 16'hFFB2;
    localparam logic [15:0] COUNT_IDX = 16'hFFB3;
    localparam logic [15:0] STAT_IDX = 16'hFFC0;
    localparam logic [15:0] MASK_IDX = 16'hFFC1;
    localparam logic [7:0] MODE_RST = 8'h78;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] RELOAD_RST = 8'h00;
    localparam logic [3:0] MODE_RSVD = 4'hF;
    localparam logic [7:0] COUNT_TOP = 8'hFF;
    localparam int unsigned MODE_BIT = 7;
    localparam int unsigned SRC_HI = 2;
    localparam int unsigned OVF_BIT = 0;
    localparam logic [2:0] SRC_RST = 3'h0;
    localparam logic [2:0] SRC_EVENT = 3'h7;
    localparam logic [13:0] DIV_8192 = 14'h2000;
    localparam logic [13:0] DIV_2048 = 14'h0800;
    localparam logic [13:0] DIV_512 = 14'h0200;
    localparam logic [13:0] DIV_256 = 14'h0100;
    localparam logic [13:0] DIV_64 = 14'h0040;
    localparam logic [13:0] DIV_16 = 14'h0010;
    localparam logic [13:0] DIV_4 = 14'h0004;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic {EBRT_RD_IDLE, EBRT_RD_RESP} ebrt_rd_t;
    typedef enum logic [1:0] {EBRT_WR_COLLECT, EBRT_WR_RESP} ebrt_wr_t;
endpackage : ebrt_pkg

//--- ebrt_tick_if.sv
// Purpose: count-source signals between the timer and its tick sources
// Assumes: one clock domain
// Notes: ticks are one-cycle pulses
`timescale 1ns/100ps
`default_nettype none
interface ebrt_tick_if;
    logic [2:0] clk_sel;
    logic halt;
    logic edge_rise;
    logic pre_tick;
    logic evt_tick;
    modport prescaler (input clk_sel, input halt, output pre_tick);
    modport evsync (input edge_rise, output evt_tick);
    modport core (output clk_sel, output halt, output edge_rise, input pre_tick, input evt_tick);
endinterface : ebrt_tick_if
`default_nettype wire

//--- ebrt_prescaler.sv
// Purpose: system clock prescaler with seven selectable taps
// Assumes: divisors are powers of two, at most 8192
// Notes: stops with the timer in low-power states
`timescale 1ns/100ps
`default_nettype none
module ebrt_prescaler
    import ebrt_pkg::*;
#(
    parameter logic [13:0] SLOW_DIV = DIV_8192
) (
    input wire logic clk,
    input wire logic rst,
    ebrt_tick_if.prescaler tk
);
    logic [12:0] cnt_q;
    logic [12:0] mask;

    function automatic logic [12:0] tap_mask(input logic [2:0] sel);
        logic [13:0] div;
        case (sel)
            3'h0: div = SLOW_DIV;
            3'h1: div = DIV_2048;
            3'h2: div = DIV_512;
            3'h3: div = DIV_256;
            3'h4: div = DIV_64;
            3'h5: div = DIV_16;
            default: div = DIV_4;
        endcase
        tap_mask = 13'(div - 14'h0001);
    endfunction : tap_mask

    always_comb begin
        mask = tap_mask(tk.clk_sel);
    end

    // ****************************************
    // Free-running divider
    // ****************************************
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 13'h0000;
        end else if (!tk.halt) begin
            cnt_q <= cnt_q + 13'h0001;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tk.pre_tick <= 1'b0;
        end else begin
            tk.pre_tick <= !tk.halt && ((cnt_q & mask) == mask);
        end
    end
endmodule : ebrt_prescaler
`default_nettype wire

//--- ebrt_event_sync.sv
// Purpose: synchronise the event pin and pick out the chosen edge
// Assumes: pin is asynchronous to clk
// Notes: a level counts once the second and third stages agree
`timescale 1ns/100ps
`default_nettype none
module ebrt_event_sync
    import ebrt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    ebrt_tick_if.evsync tk
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;
    logic agree;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_comb begin
        agree = (s2_q == s3_q);
    end

    // Accepted level; each change is seen once
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lvl_q <= 1'b0;
        end else if (agree) begin
            lvl_q <= s3_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tk.evt_tick <= 1'b0;
        end else begin
            tk.evt_tick <= agree && (s3_q != lvl_q) && (s3_q == tk.edge_rise);
        end
    end
endmodule : ebrt_event_sync
`default_nettype wire

//--- ebrt_event_src.sv
// Purpose: event pin source standing outside the timer
// Assumes: pin idles low between bursts
// Notes: pulse count and width are set per burst
`timescale 1ns/100ps
`default_nettype none
module ebrt_event_src (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] num,
    input wire logic [3:0] wid,
    output logic pin,
    output logic busy
);
    int i;
    initial begin
        pin = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'b1;
                for (i = 0; i < num; i++) begin
                    repeat (wid) @(posedge clk);
                    pin <= 1'b1;
                    repeat (wid) @(posedge clk);
                    pin <= 1'b0;
                end
                // Let the pin synchroniser drain before reporting idle
                repeat (8) @(posedge clk);
                busy <= 1'b0;
            end
        end
    end
endmodule : ebrt_event_src
`default_nettype wire

//--- ebrt_timer_bench.sv
// Purpose: self-checking bench for the reload event timer
// Assumes: slow tap shortened to 32 cycles
// Notes: handshakes sampled at the falling edge, driven after the rising one
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module ebrt_timer_bench
    import ebrt_pkg::*;
;
    // ****************************************
    // Signals and model state
    // ****************************************
    localparam logic [13:0] DIV_S = 14'h0020;
    logic clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0, edge_sel = 1'b1, halt = 1'b0, go = 1'b0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic [3:0] wstrb_v = 4'hF, num = 4'h0, wid = 4'h2;
    logic awready, wready, bvalid, arready, rvalid, irq, pin, busy;
    logic [1:0] bresp, rresp, wr_resp, rd_resp;
    logic [31:0] rdata;
    logic [7:0] rd, v, m_mode = 8'h78;
    logic [15:0] rnd = 16'h250A;
    int failures = 0, cmp_count = 0, s, k, e;
    int divs[7] = '{int'(DIV_S), 2048, 512, 256, 64, 16, 4};
    always #20 clk = ~clk;
    ebrt_timer #(.SLOW_DIV(DIV_S)) ebrt_timer_i (.clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb_v), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .event_input_pin(pin),
        .event_edge_select(edge_sel), .low_power_halt(halt), .irq(irq));
    ebrt_event_src ebrt_event_src_i (.clk(clk), .go(go), .num(num), .wid(wid),
        .pin(pin), .busy(busy));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    task automatic axw(input logic [15:0] idx, input logic [7:0] d);
        logic ap, wp, ah, wh, dn;
        int t;
        @(posedge clk);
        awaddr <= {idx, 2'h0};
        awvalid <= 1'b1;
        wdata <= {24'h000000, d};
        wvalid <= 1'b1;
        bready <= 1'b1;
        ap = 1'b1;
        wp = 1'b1;
        dn = 1'b0;
        t = 0;
        while ((ap || wp) && t < 100) begin
            @(negedge clk);
            ah = awready;
            wh = wready;
            @(posedge clk);
            if (ap && ah === 1'b1) begin
                awvalid <= 1'b0;
                ap = 1'b0;
            end
            if (wp && wh === 1'b1) begin
                wvalid <= 1'b0;
                wp = 1'b0;
            end
            t++;
        end
        while (!dn && t < 200) begin
            @(negedge clk);
            if (bvalid === 1'b1) begin
                wr_resp = bresp;
                dn = 1'b1;
            end
            @(posedge clk);
            t++;
        end
        bready <= 1'b0;
        if (!dn) begin
            failures++;
            $display("[ERR] %0t write hung", $time);
        end
        // Model: bits 6 to 3 always one, and only an enabled low lane lands
        if (dn && idx == MODE_IDX && wstrb_v[0] === 1'b1) begin
            m_mode = {d[7], 4'hF, d[2:0]};
        end
    endtask : axw
    task automatic axr(input logic [15:0] idx);
        logic ap, ah, dn;
        int t;
        @(posedge clk);
        araddr <= {idx, 2'h0};
        arvalid <= 1'b1;
        rready <= 1'b1;
        ap = 1'b1;
        dn = 1'b0;
        t = 0;
        while (ap && t < 100) begin
            @(negedge clk);
            ah = arready;
            @(posedge clk);
            if (ah === 1'b1) begin
                arvalid <= 1'b0;
                ap = 1'b0;
            end
            t++;
        end
        // Response may already stand at the edge that took the address
        while (!dn && t < 200) begin
            @(negedge clk);
            if (rvalid === 1'b1) begin
                rd = rdata[7:0];
                rd_resp = rresp;
                dn = 1'b1;
            end
            @(posedge clk);
            t++;
        end
        rready <= 1'b0;
        if (!dn) begin
            failures++;
            $display("[ERR] %0t read hung", $time);
        end
    endtask : axr
    task automatic chk_rd(input logic [15:0] idx, input logic [7:0] x);
        axr(idx);
        `CHK(rd, x)
    endtask : chk_rd
    task automatic wait_irq(input int lim);
        int t;
        t = 0;
        do begin
            @(negedge clk);
            t++;
        end while (irq !== 1'b1 && t < lim);
        `CHK(irq, 1'b1)
    endtask : wait_irq
    task automatic tdone(input string nm);
        $display("test %s done", nm);
    endtask : tdone
    task automatic results;
        $display("counts: %0d mismatches, %0d compares", failures, cmp_count);
        if (failures == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    initial begin
        repeat (40000) @(posedge clk);
        failures++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_rd(COUNT_IDX, 8'h00);
        chk_rd(MODE_IDX, 8'h78);
        chk_rd(STAT_IDX, 8'h00);
        chk_rd(MASK_IDX, 8'h00);
        repeat (128) @(posedge clk);
        axr(COUNT_IDX);
        `CHK(rd >= 8'h03 && rd <= 8'h06, 1'b1)
        tdone("reset");
        axw(MODE_IDX, 8'h00);
        chk_rd(MODE_IDX, 8'h78);
        axw(MODE_IDX, 8'h87);
        chk_rd(MODE_IDX, 8'hFF);
        wstrb_v <= 4'h0;
        axw(MODE_IDX, 8'h00);
        `CHK(wr_resp, RESP_OKAY)
        wstrb_v <= 4'hF;
        chk_rd(MODE_IDX, m_mode);
        axw(16'h0100, 8'h55);
        `CHK(wr_resp, RESP_SLVERR)
        axr(16'h0100);
        `CHK(rd_resp, RESP_SLVERR)
        tdone("registers");
        for (s = 0; s < 7; s++) begin
            k = (s == 1) ? 2 : 4;
            axw(MODE_IDX, 8'(s));
            axw(COUNT_IDX, 8'h00);
            repeat (divs[s] * k) @(posedge clk);
            axr(COUNT_IDX);
            `CHK(rd >= 8'(k - 1) && rd <= 8'(k + 2), 1'b1)
        end
        tdone("taps");
        axw(MODE_IDX, 8'h86);
        halt <= 1'b1;
        for (s = 0; s < 3; s++) begin
            rnd = lfsr(rnd);
            axw(COUNT_IDX, rnd[7:0]);
            repeat (64) @(posedge clk);
            chk_rd(COUNT_IDX, rnd[7:0]);
        end
        chk_rd(MODE_IDX, m_mode);
        halt <= 1'b0;
        tdone("halt");
        axw(MASK_IDX, 8'h01);
        axw(MODE_IDX, 8'h06);
        axw(COUNT_IDX, 8'hFE);
        wait_irq(20);
        chk_rd(STAT_IDX, 8'h01);
        axr(COUNT_IDX);
        `CHK(rd <= 8'h02, 1'b1)
        axw(STAT_IDX, 8'h01);
        chk_rd(STAT_IDX, 8'h00);
        @(negedge clk);
        `CHK(irq, 1'b0)
        axw(MASK_IDX, 8'h00);
        axw(COUNT_IDX, 8'hFE);
        repeat (40) @(posedge clk);
        chk_rd(STAT_IDX, 8'h01);
        @(negedge clk);
        `CHK(irq, 1'b0)
        axw(STAT_IDX, 8'h01);
        tdone("interval");
        axw(MASK_IDX, 8'h01);
        axw(MODE_IDX, 8'h86);
        axw(COUNT_IDX, 8'hF0);
        wait_irq(100);
        axr(COUNT_IDX);
        `CHK(rd >= 8'hF0 && rd <= 8'hF2, 1'b1)
        // Reload of FF overflows on every tick, so the count never moves
        axw(COUNT_IDX, 8'hFF);
        repeat (20) @(posedge clk);
        chk_rd(COUNT_IDX, 8'hFF);
        axw(MASK_IDX, 8'h00);
        axw(STAT_IDX, 8'h01);
        tdone("reload");
        for (e = 0; e < 2; e++) begin
            @(posedge clk);
            edge_sel <= e[0];
            // Pin assumed routed and its own interrupt off before events are chosen
            axw(MODE_IDX, 8'h07);
            axw(COUNT_IDX, 8'h00);
            rnd = lfsr(rnd);
            v = {5'h00, rnd[2:0]} + 8'h01;
            num <= v[3:0];
            wid <= {2'h0, rnd[4:3]} + 4'h2;
            @(posedge clk);
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            k = 0;
            do begin
                @(negedge clk);
                k++;
            end while (busy === 1'b1 && k < 500);
            `CHK(busy, 1'b0)
            chk_rd(COUNT_IDX, v);
            chk_rd(COUNT_IDX, v);
        end
        tdone("events");
        results();
    end
endmodule : ebrt_timer_bench
`default_nettype wire
